//--- rtl/fastlock_ctrl_pkg.sv
// Constants for the RF fastlock and counter reset control block.
// Assumes 24-bit configuration words arrive already deserialised.
package fastlock_ctrl_pkg;
	// ----------------------------------------------------------------
	// Word layout and routing
	// ----------------------------------------------------------------
	localparam int          WORD_W           = 24;
	localparam int          SEL_W            = 4;
	localparam logic [3:0]  SEL_FASTLOCK     = 4'hd; // Fastlock control word
	localparam logic [3:0]  SEL_COUNTER      = 4'hf; // Lock detect and counter word
	// Fastlock control word fields
	localparam int          TOC_LSB          = 4;
	localparam int          TOC_W            = 14;
	localparam int          CPF_LSB          = 18;
	localparam int          CPF_W            = 4;
	localparam int          SLIP_LSB         = 22;
	localparam int          SLIP_W           = 2;
	// Lock detect and counter word fields
	localparam int          RF_FLOAT_BIT     = 4;
	localparam int          IF_FLOAT_BIT     = 5;
	localparam int          RF_CLEAR_BIT     = 6;
	localparam int          IF_CLEAR_BIT     = 7;
	localparam int          LD_QUARTER_BIT   = 13;
	// ----------------------------------------------------------------
	// Values after reset and mode codes
	// ----------------------------------------------------------------
	localparam logic [13:0] TOC_RESET        = 14'h0000;
	localparam logic [3:0]  CPF_RESET        = 4'h0;
	localparam logic [1:0]  SLIP_RESET       = 2'h0;
	localparam logic        CTRL_BIT_RESET   = 1'b0;
	localparam logic [13:0] TOC_HIZ          = 14'h0000;
	localparam logic [13:0] TOC_MANUAL       = 14'h0001;
	localparam logic [13:0] TOC_DRIVE_LOW    = 14'h0002;
	localparam logic [13:0] TOC_DRIVE_HIGH   = 14'h0003;
	localparam logic [13:0] TOC_AUTO_MIN     = 14'h0004;
	localparam logic [1:0]  LD_QUARTER_LAST  = 2'h3; // Divide by 4
	localparam int          FAST_CNT_W       = TOC_W + 1;
	localparam int          MULT_W           = CPF_W + 1;
	localparam logic [4:0]  MULT_BASE        = 5'h01;
	localparam logic [4:0]  SLIP_FACTOR_1    = 5'h01;
	localparam logic [4:0]  SLIP_FACTOR_2    = 5'h02;
	localparam logic [4:0]  SLIP_FACTOR_4    = 5'h04;
	localparam logic [4:0]  SLIP_FACTOR_16   = 5'h10;
	localparam logic [14:0] FAST_CNT_RESET   = 15'h0000;
	localparam logic [1:0]  LD_CNT_RESET     = 2'h0;
	// Pin mode of the fastlock pin
	typedef enum logic [1:0] {PIN_HIZ, PIN_LOW, PIN_HIGH, PIN_FASTLOCK} pin_mode_e;
endpackage

//--- rtl/rf_fastlock_and_counter_reset_ctrl.sv
// RF fastlock time-out control, charge pump and counter reset steering.
// Assumes the serial port hands over whole 24-bit words with a one-cycle
// strobe, and that comparison events arrive as one-cycle enables on clk.
`timescale 1ns/1ps

module rf_fastlock_and_counter_reset_ctrl
	import fastlock_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Received configuration word
	input  wire logic                wordValid,
	input  wire logic [WORD_W-1:0]   wordData,
	// Timing events
	input  wire logic                rfCompPulse,
	input  wire logic                ifCompPulse,
	input  wire logic                fastLockTrigger,
	input  wire logic                powerUp,
	// Fastlock pin
	output logic                     rfFastLockPinOut,
	output logic                     rfFastLockPinOe,
	// RF loop controls
	output logic                     fastLockActive,
	output logic [MULT_W-1:0]        rfPumpMultiple,
	output logic [4:0]               cycleSlipDivider,
	// Lock detect rates
	output logic                     rfLockDetectPulse,
	output logic                     ifLockDetectPulse,
	// Counter and pump controls
	output logic                     rfCounterReset,
	output logic                     ifCounterReset,
	output logic                     rfPumpTristate,
	output logic                     ifPumpTristate
);

	// ----------------------------------------------------------------
	// Configuration fields and internal state
	// ----------------------------------------------------------------
	logic [TOC_W-1:0]      rfTimeoutCount;
	logic [CPF_W-1:0]      rfFastPumpCurrent;
	logic [SLIP_W-1:0]     cycleSlipFactor;
	logic                  lockDetectQuarter;
	logic                  rfCounterClear;
	logic                  ifCounterClear;
	logic                  rfPumpFloat;
	logic                  ifPumpFloat;
	logic [FAST_CNT_W-1:0] fastCount;
	logic [1:0]            ldCount;
	logic                  powerUpReset;
	pin_mode_e             pinMode;

	// Word routing by its select nibble
	wire logic [SEL_W-1:0] wordSel      = wordData[SEL_W-1:0];
	wire logic             loadFastlock = wordValid && (wordSel == SEL_FASTLOCK);
	wire logic             loadCounter  = wordValid && (wordSel == SEL_COUNTER);

	// Fastlock control word: only the fields of this block are kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rfTimeoutCount    <= TOC_RESET;
			rfFastPumpCurrent <= CPF_RESET;
			cycleSlipFactor   <= SLIP_RESET;
		end else if (loadFastlock) begin
			rfTimeoutCount    <= wordData[TOC_LSB +: TOC_W];
			rfFastPumpCurrent <= wordData[CPF_LSB +: CPF_W];
			cycleSlipFactor   <= wordData[SLIP_LSB +: SLIP_W];
		end
	end

	// Lock detect and counter word; fixed bits of the word are ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lockDetectQuarter <= CTRL_BIT_RESET;
			rfCounterClear    <= CTRL_BIT_RESET;
			ifCounterClear    <= CTRL_BIT_RESET;
			rfPumpFloat       <= CTRL_BIT_RESET;
			ifPumpFloat       <= CTRL_BIT_RESET;
		end else if (loadCounter) begin
			lockDetectQuarter <= wordData[LD_QUARTER_BIT];
			rfCounterClear    <= wordData[RF_CLEAR_BIT];
			ifCounterClear    <= wordData[IF_CLEAR_BIT];
			rfPumpFloat       <= wordData[RF_FLOAT_BIT];
			ifPumpFloat       <= wordData[IF_FLOAT_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Fastlock time-out
	// ----------------------------------------------------------------
	wire logic                  autoMode   = rfTimeoutCount >= TOC_AUTO_MIN;
	wire logic                  manualMode = rfTimeoutCount == TOC_MANUAL;
	wire logic [FAST_CNT_W-1:0] fastLoad   = {rfTimeoutCount, 1'b0};
	wire logic                  autoActive = fastCount != FAST_CNT_RESET;

	// Load wins over a same-cycle decrement; leaving auto mode aborts at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fastCount <= FAST_CNT_RESET;
		end else if (!autoMode) begin
			fastCount <= FAST_CNT_RESET;
		end else if (fastLockTrigger) begin
			fastCount <= fastLoad;
		end else if (rfCompPulse && autoActive) begin
			fastCount <= fastCount - 1'b1;
		end
	end

	assign fastLockActive = manualMode || (autoMode && autoActive);

	// Pin mode decode; in auto mode the pin pulls low while fastlock runs, otherwise it floats
	assign pinMode = autoMode                          ? PIN_FASTLOCK :
	                 (rfTimeoutCount == TOC_HIZ)       ? PIN_HIZ :
	                 (rfTimeoutCount == TOC_DRIVE_HIGH) ? PIN_HIGH : PIN_LOW;

	always_comb begin
		rfFastLockPinOut = 1'b0;
		rfFastLockPinOe  = 1'b0;
		unique case (pinMode)
			PIN_HIZ: begin
				rfFastLockPinOe = 1'b0;
			end
			PIN_LOW: begin
				rfFastLockPinOe = 1'b1;
			end
			PIN_HIGH: begin
				rfFastLockPinOut = 1'b1;
				rfFastLockPinOe  = 1'b1;
			end
			PIN_FASTLOCK: begin
				rfFastLockPinOe = autoActive;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pump current and cycle slip factor
	// ----------------------------------------------------------------
	wire logic [MULT_W-1:0] fastMultiple = {1'b0, rfFastPumpCurrent} + MULT_BASE;
	assign rfPumpMultiple   = fastLockActive ? fastMultiple : MULT_BASE;
	// Divider of the sample rate; 1 means reduction is off
	assign cycleSlipDivider = (cycleSlipFactor == 2'h0) ? SLIP_FACTOR_1 :
	                          (cycleSlipFactor == 2'h1) ? SLIP_FACTOR_2 :
	                          (cycleSlipFactor == 2'h2) ? SLIP_FACTOR_4 : SLIP_FACTOR_16;

	// ----------------------------------------------------------------
	// Lock detect rate
	// ----------------------------------------------------------------
	// Counter free-runs on comparison events so the divided rate stays even
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ldCount <= LD_CNT_RESET;
		end else if (rfCompPulse) begin
			ldCount <= ldCount + 1'b1;
		end
	end

	assign rfLockDetectPulse = rfCompPulse && (!lockDetectQuarter || ldCount == LD_QUARTER_LAST);
	assign ifLockDetectPulse = ifCompPulse;

	// ----------------------------------------------------------------
	// Counter reset and pump float
	// ----------------------------------------------------------------
	// Power-up stretched by one register so a one-cycle pulse resets the counters for two cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			powerUpReset <= 1'b0;
		end else begin
			powerUpReset <= powerUp;
		end
	end

	assign rfCounterReset = rfCounterClear || powerUp || powerUpReset;
	assign ifCounterReset = ifCounterClear || powerUp || powerUpReset;
	// A counter reset always floats its pump; float alone leaves counters running
	assign rfPumpTristate = rfCounterReset || rfPumpFloat;
	assign ifPumpTristate = ifCounterReset || ifPumpFloat;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_start;
		autoMode && fastLockTrigger && !wordValid;
	endsequence

	sequence s_hold;
		fastLockActive && !rfCompPulse && !fastLockTrigger && !wordValid;
	endsequence

	property p_pin_levels;
		@(posedge clk) disable iff (!rst_n)
		!autoMode |-> rfFastLockPinOe == (rfTimeoutCount != TOC_HIZ) &&
			rfFastLockPinOut == (rfTimeoutCount == TOC_DRIVE_HIGH);
	endproperty
	a_pin_levels: assert property (p_pin_levels) else $error("fastlock pin wrong in I/O mode");

	property p_auto_start;
		@(posedge clk) disable iff (!rst_n)
		s_start |=> fastLockActive && rfFastLockPinOe && fastCount == 2 * $past(rfTimeoutCount);
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("fastlock did not start with twice the count");

	property p_auto_step;
		@(posedge clk) disable iff (!rst_n)
		autoActive && autoMode && rfCompPulse && !fastLockTrigger && !wordValid |=>
			fastCount == $past(fastCount) - 1;
	endproperty
	a_auto_step: assert property (p_auto_step) else $error("fastlock count did not step");

	property p_auto_hold;
		@(posedge clk) disable iff (!rst_n)
		!manualMode ##0 s_hold[*2] |-> fastCount == $past(fastCount, 1);
	endproperty
	a_auto_hold: assert property (p_auto_hold) else $error("fastlock count moved without an event");

	property p_manual;
		@(posedge clk) disable iff (!rst_n)
		manualMode |-> fastLockActive && rfFastLockPinOe && !rfFastLockPinOut;
	endproperty
	a_manual: assert property (p_manual) else $error("manual fastlock not forced");

	property p_pump_mult;
		@(posedge clk) disable iff (!rst_n)
		rfPumpMultiple == (fastLockActive ? rfFastPumpCurrent + 5'd1 : 5'd1);
	endproperty
	a_pump_mult: assert property (p_pump_mult) else $error("pump multiple wrong");

	property p_slip;
		@(posedge clk) disable iff (!rst_n)
		cycleSlipDivider == (5'd1 << (cycleSlipFactor == 2'h3 ? 4 : cycleSlipFactor));
	endproperty
	a_slip: assert property (p_slip) else $error("cycle slip factor wrong");

	property p_ld_quarter;
		@(posedge clk) disable iff (!rst_n)
		lockDetectQuarter && rfLockDetectPulse ##1 (rfCompPulse && lockDetectQuarter)[*3] |-> !rfLockDetectPulse;
	endproperty
	a_ld_quarter: assert property (p_ld_quarter) else $error("lock detect not divided by four");

	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		loadCounter |=> rfCounterReset == ($past(wordData[RF_CLEAR_BIT]) || powerUp || powerUpReset) &&
			(ifCounterReset -> ifPumpTristate) && (rfCounterReset -> rfPumpTristate);
	endproperty
	a_clear: assert property (p_clear) else $error("counter clear not applied");

	property p_power_up;
		@(posedge clk) disable iff (!rst_n)
		powerUp |-> (rfCounterReset && ifCounterReset)[*2];
	endproperty
	a_power_up: assert property (p_power_up) else $error("power-up reset too short");

	property p_float;
		@(posedge clk) disable iff (!rst_n)
		!rfCounterReset && !ifCounterReset |-> rfPumpTristate == rfPumpFloat && ifPumpTristate == ifPumpFloat;
	endproperty
	a_float: assert property (p_float) else $error("pump float wrong");

endmodule

//--- test/host_word_writer.sv
// Host controller model: hands whole configuration words to the control block.
// Assumes the bench raises sendReq for one cycle per word, away from the rising edge.
`timescale 1ns/1ps

module host_word_writer
	import fastlock_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Commands from the bench
	input  wire logic              sendReq,
	input  wire logic [WORD_W-1:0] sendWord,
	input  wire logic              fastCompare,
	input  wire logic              holdIdle,
	// Word strobe towards the block
	output logic                   wordValid,
	output logic [WORD_W-1:0]      wordData
);
	// ----------------------------------------------------------------
	// Host habits
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] shaped;

	// Quarter bit forced at high comparison rates; clear bits kept low unless idling on purpose
	always_comb begin
		shaped = sendWord;
		if (sendWord[3:0] == SEL_COUNTER && fastCompare)
			shaped[LD_QUARTER_BIT] = 1'b1;
		if (sendWord[3:0] == SEL_COUNTER && !holdIdle) begin
			shaped[RF_CLEAR_BIT] = 1'b0;
			shaped[IF_CLEAR_BIT] = 1'b0;
		end
	end

	// One-cycle strobe; data scrambles outside it so a stale word never looks fresh
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wordValid <= 1'b0;
			wordData  <= '0;
		end else begin
			wordValid <= sendReq;
			wordData  <= sendReq ? shaped : ~wordData;
		end
	end
endmodule

//--- test/rf_fastlock_and_counter_reset_ctrl_bench.sv
// Self-checking bench for the fastlock and counter reset control block.
// Assumes the host model in host_word_writer.sv; inputs change at falling edges.
`timescale 1ns/1ps

module rf_fastlock_and_counter_reset_ctrl_bench;
	import fastlock_ctrl_pkg::*;
	logic              clk, rst_n, sendReq, fastCompare, holdIdle, wordValid;
	logic              rfCompPulse, ifCompPulse, fastLockTrigger, powerUp;
	logic              pinOut, pinOe, active, rfLd, ifLd, rfRst, ifRst, rfTri, ifTri;
	logic [WORD_W-1:0] sendWord, wordData;
	logic [4:0]        mult, divider;
	logic [13:0]       toc;
	logic [3:0]        cpf, bits;
	int                errors, num_checks, cycles, cnt, hits;

	host_word_writer i_host_word_writer (.clk(clk), .rst_n(rst_n), .sendReq(sendReq), .sendWord(sendWord),
		.fastCompare(fastCompare), .holdIdle(holdIdle), .wordValid(wordValid), .wordData(wordData));
	rf_fastlock_and_counter_reset_ctrl i_rf_fastlock_and_counter_reset_ctrl (.clk(clk), .rst_n(rst_n),
		.wordValid(wordValid), .wordData(wordData), .rfCompPulse(rfCompPulse), .ifCompPulse(ifCompPulse),
		.fastLockTrigger(fastLockTrigger), .powerUp(powerUp), .rfFastLockPinOut(pinOut),
		.rfFastLockPinOe(pinOe), .fastLockActive(active), .rfPumpMultiple(mult), .cycleSlipDivider(divider),
		.rfLockDetectPulse(rfLd), .ifLockDetectPulse(ifLd), .rfCounterReset(rfRst), .ifCounterReset(ifRst),
		.rfPumpTristate(rfTri), .ifPumpTristate(ifTri));

	// ----------------------------------------------------------------
	// Clock, hang guard and helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Longest case is the 32766-pulse fastlock; the ceiling leaves margin above it
	always @(posedge clk) begin
		cycles++;
		if (cycles == 45000) begin
			errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] expv, input logic [15:0] got);
		num_checks++;
		if (got !== expv) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, expv, got);
		end
	endtask

	// Entered at a falling edge; returns at the falling edge after the block took the word
	task automatic send(input logic [23:0] w);
		sendWord = w;
		sendReq = 1'b1;
		@(negedge clk);
		sendReq = 1'b0;
		@(negedge clk);
	endtask

	// Pin as {enable, value}; auto mode drives low only while fastlock runs
	function automatic logic [1:0] exp_pin(input logic [13:0] c, input logic run);
		if (c == 14'h0000)
			return 2'b00;
		if (c == 14'h0001 || c == 14'h0002)
			return 2'b10;
		if (c == 14'h0003)
			return 2'b11;
		return {run, 1'b0};
	endfunction

	function automatic logic [4:0] exp_div(input logic [1:0] code);
		return (code == 2'h3) ? 5'h10 : 5'h01 << code;
	endfunction

	task automatic look(input logic run);
		check("pin", 16'(exp_pin(toc, run)), 16'({pinOe, pinOut}));
		check("active", 16'(run), 16'(active));
		check("mult", run ? 16'(cpf) + 16'h1 : 16'h1, 16'(mult));
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{sendReq, fastCompare, holdIdle, rfCompPulse, ifCompPulse, fastLockTrigger, powerUp} = '0;
		sendWord = '0;
		rst_n = 1'b0;
		toc = '0;
		cpf = '0;
		void'($urandom(32'h2f6022f1));
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		look(1'b0);
		check("divider", 16'h1, 16'(divider));
		// Every pin code, current code and slip code; trigger refused outside auto mode
		for (int k = 0; k < 16; k++) begin
			toc = 14'(k % 4);
			cpf = 4'(k);
			send({2'(k), cpf, toc, 4'hd});
			look(toc == 14'h1);
			check("divider", 16'(exp_div(2'(k))), 16'(divider));
			fastLockTrigger = 1'b1;
			@(negedge clk);
			fastLockTrigger = 1'b0;
			look(toc == 14'h1);
		end
		send({20'hfffff, 4'he});
		look(1'b0);
		// Automatic fastlock at the low and high boundary and a random count
		for (int r = 0; r < 3; r++) begin
			toc = (r == 0) ? 14'h0004 : (r == 1) ? 14'h3fff : 14'(4 + ($urandom % 21));
			cpf = 4'($urandom);
			send({2'h0, cpf, toc, 4'hd});
			look(1'b0);
			fastLockTrigger = 1'b1;
			@(negedge clk);
			fastLockTrigger = 1'b0;
			cnt = 0;
			while (cnt < 2 * toc) begin
				look(1'b1);
				rfCompPulse = (toc > 14'd100) ? 1'b1 : 1'($urandom);
				if (rfCompPulse)
					cnt++;
				@(negedge clk);
			end
			rfCompPulse = 1'b0;
			look(1'b0);
		end
		// Rewriting the count below four aborts a running fastlock at once
		fastLockTrigger = 1'b1;
		@(negedge clk);
		fastLockTrigger = 1'b0;
		look(1'b1);
		toc = 14'h0002;
		send({2'h0, cpf, toc, 4'hd});
		look(1'b0);
		// Lock detect rates, quarter bit supplied by the host at a high rate
		for (int q = 0; q < 2; q++) begin
			fastCompare = 1'(q);
			send(24'h00000f);
			hits = 0;
			for (int i = 0; i < 16; i++) begin
				rfCompPulse = 1'b1;
				ifCompPulse = 1'($urandom);
				#1;
				if (rfLd === 1'b1)
					hits++;
				check("ifLd", 16'(ifCompPulse), 16'(ifLd));
				@(negedge clk);
			end
			rfCompPulse = 1'b0;
			check("rfLd count", (q == 1) ? 16'd4 : 16'd16, 16'(hits));
		end
		fastCompare = 1'b0;
		// Float and clear bits, one at a time then random mixes
		holdIdle = 1'b1;
		for (int i = 0; i < 8; i++) begin
			bits = (i < 4) ? 4'(1 << i) : 4'($urandom);
			send({16'h0000, bits, 4'hf});
			check("rfRst", 16'(bits[2]), 16'(rfRst));
			check("ifRst", 16'(bits[3]), 16'(ifRst));
			check("rfTri", 16'(bits[2] | bits[0]), 16'(rfTri));
			check("ifTri", 16'(bits[3] | bits[1]), 16'(ifTri));
		end
		// Power-up pulse resets both loops for two cycles
		send(24'h00000f);
		powerUp = 1'b1;
		#1;
		check("rfRst", 16'h1, 16'(rfRst));
		check("ifTri", 16'h1, 16'(ifTri));
		@(negedge clk);
		powerUp = 1'b0;
		#1;
		check("ifRst", 16'h1, 16'(ifRst));
		@(negedge clk);
		check("rfRst", 16'h0, 16'(rfRst));
		finish_test();
	end
endmodule
